// >>> logic/lmc_ctrl.sv
// Purpose: digital mode control of two LIN transceiver channels
// Assumes: all inputs synchronous to i_clock; bus level 0 is dominant
// Notes:   wake events are queued as {channel b, channel a, stop, normal} words
`timescale 1ns/1ps
`include "lmc_cfg.svh"

// Summary of operation
// - channels start off; off allowed except in fail-safe; bus wake ignored while off.
// - normal channel mode accepted only in normal power mode.
// - in normal mode bus follows transmit input; receive output mirrors bus.
// - sending starts with the first dominant bit that starts after enable time.
// - receive-only disables driver; selectable in normal and stop power modes.
// - wake-capable selectable in stop, sleep, restart, normal; forced in fail-safe.
// - wake needs falling edge, dominant beyond filter time, then rising edge.
// - wake filter time lies between 30 and 150 microseconds.
// - after wake receive output stays low until channel mode changes or wake is rearmed.
// - wake reaction per power mode; sleep and fail-safe go to restart.
// - mode field keeps reading wake-capable code while receive output held low.
// - leaving wake-capable and returning rearms wake detection.
// - entering stop, sleep or fail-safe, or stop again, rearms wake.
// - wake in stop or normal raises interrupt and sets bus wake status.
// - stop-mode bus wake enables a disabled watchdog if allowed beforehand.
// - sleep wake goes restart then normal, records source, no interrupt.
// - transmit input dominant past timeout disables driver and sets fault flag.
// - timed-out driver recovers once transmit input is released.
// - one bit disables transmit timeout for all channels.
// - bus dominant past timeout in normal or receive-only sets fault flag.
// - transceiver undervoltage forces receive-only behaviour until supply recovers.
// - low slope selection applied at chip select rise in normal power mode only.
// - flash speed disables slope control at chip select rise in normal mode.
module lmc_ctrl #(
  parameter int TX_EN_CYC  = `LMC_TX_EN_CYC,
  parameter int DOM_TO_CYC = `LMC_DOM_TO_CYC
) (
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_sys_rst,
  // chip power mode
  input  wire lmc_pkg::lmc_pwr_mode_t i_pwr_mode,
  input  wire logic                   i_pwr_mode_wr,
  output logic                        o_restart_req,
  output logic                        o_normal_req,
  // spi configuration
  input  wire logic [1:0]             i_mode_a_wr_val,
  input  wire logic [1:0]             i_mode_b_wr_val,
  input  wire logic                   i_mode_wr,
  input  wire logic                   i_tx_timeout_disable,
  input  wire logic                   i_low_slope_select,
  input  wire logic                   i_flash_speed_enable,
  input  wire logic                   i_spi_cs_n,
  input  wire logic                   i_watchdog_on_bus_wake,
  input  wire logic                   i_fault_clr,
  input  wire logic                   i_wake_stat_clr,
  // status
  output lmc_pkg::lmc_ch_mode_t       o_channel_a_mode_field,
  output lmc_pkg::lmc_ch_mode_t       o_channel_b_mode_field,
  output logic                        o_ch_a_fault_flag,
  output logic                        o_ch_b_fault_flag,
  output logic [1:0]                  o_wake_source_status,
  output logic                        o_low_slope,
  output logic                        o_slope_off,
  output logic                        o_watchdog_enable_set,
  output logic                        o_int_n,
  // wake event queue drain
  output logic                        o_wake_evt_valid,
  input  wire logic                   i_wake_evt_ready,
  output logic [3:0]                  o_wake_evt_data,
  // supply
  input  wire logic                   i_transceiver_supply_uv,
  // per channel pins, index 0 = a
  input  wire logic [1:0]             i_lin_transmit_input,
  output logic      [1:0]             o_lin_receive_output,
  input  wire logic [1:0]             i_lin_bus,
  output logic      [1:0]             o_lin_bus,
  output logic      [1:0]             o_lin_bus_oe
);
  import lmc_pkg::*;

  lmc_ch_mode_t       mode_q [2];
  logic [1:0]         armed_q;
  logic [1:0]         woke_q;
  logic [1:0]         bus_prev_q;
  logic [1:0]         wk_dom_q;
  logic [`LMC_CNT_W-1:0] wk_cnt_q  [2];
  logic [`LMC_CNT_W-1:0] en_cnt_q  [2];
  logic [`LMC_CNT_W-1:0] txd_cnt_q [2];
  logic [`LMC_CNT_W-1:0] bus_cnt_q [2];
  logic [1:0]         en_done_q;
  logic [1:0]         tx_gate_q;
  logic [1:0]         tx_prev_q;
  logic [1:0]         txto_q;
  logic [1:0]         fault_q;
  logic [1:0]         wake_evt;
  logic               cs_prev_q;
  logic               lsm_pend_q;
  logic               fls_pend_q;
  logic               in_ready;
  logic [1:0]         drive;
  logic               any_wake;
  logic [1:0]         wake_stat_q;
  logic               restart_q;

  // ===========================================================
  // helpers
  function automatic lmc_ch_mode_t accept_mode(input lmc_ch_mode_t cur,
                                                input logic [1:0] req,
                                                input lmc_pwr_mode_t pm);
    lmc_ch_mode_t r;
    r = cur;
    case (req)
      2'b00:   r = LMC_CH_OFF;
      2'b11:   if (pm == LMC_PM_NORMAL) r = LMC_CH_NORM;
      2'b10:   if (pm == LMC_PM_NORMAL || pm == LMC_PM_STOP) r = LMC_CH_RXO;
      2'b01:   if (pm != LMC_PM_FAILSAF) r = LMC_CH_WAKE;
      default: r = cur;
    endcase
    return r;
  endfunction

  function automatic logic [`LMC_CNT_W-1:0] sat_inc(input logic [`LMC_CNT_W-1:0] c);
    return (&c) ? c : c + 1'b1;
  endfunction

  wire rearm_pm = i_pwr_mode_wr && (i_pwr_mode == LMC_PM_STOP ||
                  i_pwr_mode == LMC_PM_SLEEP || i_pwr_mode == LMC_PM_FAILSAF);

  // ===========================================================
  // channel logic
  for (genvar c = 0; c < 2; c++) begin : g_ch
    lmc_ch_mode_t nxt;
    always_comb begin
      nxt = (i_mode_wr) ? accept_mode(mode_q[c], (c == 0) ? i_mode_a_wr_val
                                      : i_mode_b_wr_val, i_pwr_mode) : mode_q[c];
      if (i_pwr_mode == LMC_PM_FAILSAF) begin
        nxt = LMC_CH_WAKE;
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        mode_q[c]  <= LMC_CH_OFF;
        armed_q[c] <= 1'b1;
        woke_q[c]  <= 1'b0;
      end else begin
        mode_q[c] <= nxt;
        if (nxt != mode_q[c]) begin
          woke_q[c]  <= 1'b0;
          armed_q[c] <= 1'b1;
        end else if (rearm_pm) begin
          woke_q[c]  <= 1'b0;
          armed_q[c] <= 1'b1;
        end else if (wake_evt[c]) begin
          woke_q[c]  <= 1'b1;
          armed_q[c] <= 1'b0;
        end
      end
    end

    // wake filter: falling edge, long dominant, rising edge
    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        bus_prev_q[c] <= 1'b1;
        wk_dom_q[c]   <= 1'b0;
        wk_cnt_q[c]   <= '0;
      end else begin
        bus_prev_q[c] <= i_lin_bus[c];
        if (bus_prev_q[c] && !i_lin_bus[c]) begin
          wk_dom_q[c] <= 1'b1;
          wk_cnt_q[c] <= '0;
        end else if (!i_lin_bus[c] && wk_dom_q[c]) begin
          wk_cnt_q[c] <= sat_inc(wk_cnt_q[c]);
        end else if (i_lin_bus[c]) begin
          wk_dom_q[c] <= 1'b0;
        end
      end
    end
    assign wake_evt[c] = (mode_q[c] == LMC_CH_WAKE) && armed_q[c] && wk_dom_q[c] &&
                         !bus_prev_q[c] && i_lin_bus[c] &&
                         (wk_cnt_q[c] >= `LMC_CNT_W'(`LMC_WAKE_FILT_CYC));

    // enable sequence and transmit timeout
    always_ff @(posedge i_clock) begin
      if (i_sys_rst || mode_q[c] != LMC_CH_NORM) begin
        en_cnt_q[c]  <= '0;
        en_done_q[c] <= 1'b0;
        tx_gate_q[c] <= 1'b0;
      end else begin
        if (!en_done_q[c]) begin
          en_cnt_q[c] <= sat_inc(en_cnt_q[c]);
          if (en_cnt_q[c] >= `LMC_CNT_W'(TX_EN_CYC - 1)) begin
            en_done_q[c] <= 1'b1;
          end
        end
        // early low is held off until it returns high
        if (en_done_q[c] && tx_prev_q[c] && !i_lin_transmit_input[c]) begin
          tx_gate_q[c] <= 1'b1;
        end
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        tx_prev_q[c] <= 1'b1;
        txd_cnt_q[c] <= '0;
        txto_q[c]    <= 1'b0;
        bus_cnt_q[c] <= '0;
        fault_q[c]   <= 1'b0;
      end else begin
        tx_prev_q[c] <= i_lin_transmit_input[c];
        if (i_lin_transmit_input[c]) begin
          txd_cnt_q[c] <= '0;
          txto_q[c]    <= 1'b0;
        end else begin
          txd_cnt_q[c] <= sat_inc(txd_cnt_q[c]);
          if (!i_tx_timeout_disable && mode_q[c] == LMC_CH_NORM &&
              txd_cnt_q[c] >= `LMC_CNT_W'(DOM_TO_CYC - 1)) begin
            txto_q[c] <= 1'b1;
          end
        end
        bus_cnt_q[c] <= i_lin_bus[c] ? '0 : sat_inc(bus_cnt_q[c]);
        // set wins over clear
        if ((!i_tx_timeout_disable && mode_q[c] == LMC_CH_NORM && !i_lin_transmit_input[c] &&
             txd_cnt_q[c] >= `LMC_CNT_W'(DOM_TO_CYC - 1)) ||
            ((mode_q[c] == LMC_CH_NORM || mode_q[c] == LMC_CH_RXO) &&
             bus_cnt_q[c] >= `LMC_CNT_W'(DOM_TO_CYC - 1))) begin
          fault_q[c] <= 1'b1;
        end else if (i_fault_clr) begin
          fault_q[c] <= 1'b0;
        end
      end
    end

    assign drive[c] = (mode_q[c] == LMC_CH_NORM) && tx_gate_q[c] && !txto_q[c] &&
                      !i_transceiver_supply_uv;
    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        o_lin_bus_oe[c]         <= 1'b0;
        o_lin_receive_output[c] <= 1'b1;
      end else begin
        o_lin_bus_oe[c] <= drive[c] && !i_lin_transmit_input[c];
        if (woke_q[c] || wake_evt[c]) begin
          o_lin_receive_output[c] <= 1'b0;
        end else if (mode_q[c] == LMC_CH_NORM || mode_q[c] == LMC_CH_RXO) begin
          o_lin_receive_output[c] <= i_lin_bus[c];
        end else begin
          o_lin_receive_output[c] <= 1'b1;
        end
      end
    end
  end

  assign o_lin_bus              = 2'b00;
  assign o_channel_a_mode_field = mode_q[0];
  assign o_channel_b_mode_field = mode_q[1];
  assign o_ch_a_fault_flag      = fault_q[0];
  assign o_ch_b_fault_flag      = fault_q[1];
  assign any_wake               = |wake_evt;

  // ===========================================================
  // chip level wake reaction
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wake_stat_q           <= 2'b00;
      o_int_n               <= 1'b1;
      o_watchdog_enable_set <= 1'b0;
      restart_q             <= 1'b0;
      o_restart_req         <= 1'b0;
      o_normal_req          <= 1'b0;
    end else begin
      o_watchdog_enable_set <= any_wake && i_pwr_mode == LMC_PM_STOP &&
                               i_watchdog_on_bus_wake;
      o_restart_req         <= any_wake && (i_pwr_mode == LMC_PM_SLEEP ||
                               i_pwr_mode == LMC_PM_FAILSAF);
      if (any_wake && i_pwr_mode == LMC_PM_SLEEP) begin
        restart_q <= 1'b1;
      end else if (restart_q && i_pwr_mode == LMC_PM_RESTART) begin
        restart_q <= 1'b0;
      end
      o_normal_req <= restart_q && i_pwr_mode == LMC_PM_RESTART;
      if (any_wake) begin
        wake_stat_q <= wake_stat_q | wake_evt;
      end else if (i_wake_stat_clr) begin
        wake_stat_q <= 2'b00;
      end
      if (any_wake && (i_pwr_mode == LMC_PM_NORMAL || i_pwr_mode == LMC_PM_STOP)) begin
        o_int_n <= 1'b0;
      end else if (i_wake_stat_clr) begin
        o_int_n <= 1'b1;
      end
    end
  end
  assign o_wake_source_status = wake_stat_q;

  // ===========================================================
  // slope selection, latched at chip select rising
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      cs_prev_q   <= 1'b1;
      lsm_pend_q  <= 1'b0;
      fls_pend_q  <= 1'b0;
      o_low_slope <= 1'b0;
      o_slope_off <= 1'b0;
    end else begin
      cs_prev_q <= i_spi_cs_n;
      if (!i_spi_cs_n && i_pwr_mode == LMC_PM_NORMAL) begin
        lsm_pend_q <= i_low_slope_select;
        fls_pend_q <= i_flash_speed_enable;
      end
      if (!cs_prev_q && i_spi_cs_n) begin
        o_low_slope <= lsm_pend_q;
        o_slope_off <= fls_pend_q;
      end
    end
  end

  // ===========================================================
  // wake event queue
  lmc_fifo #(
    .WIDTH (4),
    .DEPTH (`LMC_FIFO_DEPTH)
  ) u_fifo (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (any_wake),
    .o_in_ready  (in_ready),
    .i_in_data   ({wake_evt, i_pwr_mode == LMC_PM_STOP, i_pwr_mode == LMC_PM_NORMAL}),
    .o_out_valid (o_wake_evt_valid),
    .i_out_ready (i_wake_evt_ready),
    .o_out_data  (o_wake_evt_data)
  );

  // ===========================================================
  // checks
  property p_off_reset;
    @(posedge i_clock) i_sys_rst |=> mode_q[0] == LMC_CH_OFF && mode_q[1] == LMC_CH_OFF;
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("mode not off after reset");

  property p_norm_pm;
    @(posedge i_clock) disable iff (i_sys_rst)
      (mode_q[0] == LMC_CH_NORM && !$past(mode_q[0] == LMC_CH_NORM)) |->
      $past(i_pwr_mode) == LMC_PM_NORMAL;
  endproperty
  a_norm_pm: assert property (p_norm_pm) else $error("normal mode outside normal pm");

  property p_no_drive_off;
    @(posedge i_clock) disable iff (i_sys_rst)
      (mode_q[0] != LMC_CH_NORM) |=> !o_lin_bus_oe[0];
  endproperty
  a_no_drive_off: assert property (p_no_drive_off) else $error("drive outside normal");

  property p_uv;
    @(posedge i_clock) disable iff (i_sys_rst) i_transceiver_supply_uv |=> !o_lin_bus_oe[0];
  endproperty
  a_uv: assert property (p_uv) else $error("driving under undervoltage");

  sequence s_wake0;
    wake_evt[0] ##1 (mode_q[0] == LMC_CH_WAKE);
  endsequence
  property p_rx_low;
    @(posedge i_clock) disable iff (i_sys_rst) s_wake0 |-> !o_lin_receive_output[0];
  endproperty
  a_rx_low: assert property (p_rx_low) else $error("rx not low after wake");

  property p_wake_stat;
    @(posedge i_clock) disable iff (i_sys_rst) wake_evt[0] |=> wake_stat_q[0];
  endproperty
  a_wake_stat: assert property (p_wake_stat) else $error("wake status missing");

  property p_sleep_no_int;
    @(posedge i_clock) disable iff (i_sys_rst)
      (any_wake && i_pwr_mode == LMC_PM_SLEEP && o_int_n) |=> o_int_n;
  endproperty
  a_sleep_no_int: assert property (p_sleep_no_int) else $error("int on sleep wake");

  property p_txto;
    @(posedge i_clock) disable iff (i_sys_rst) txto_q[0] |=> !o_lin_bus_oe[0] && fault_q[0];
  endproperty
  a_txto: assert property (p_txto) else $error("timeout did not stop driver");

  property p_txto_dis;
    @(posedge i_clock) disable iff (i_sys_rst)
      (i_tx_timeout_disable && !txto_q[0]) |=> !txto_q[0];
  endproperty
  a_txto_dis: assert property (p_txto_dis) else $error("timeout while disabled");

  property p_evt_room;
    @(posedge i_clock) disable iff (i_sys_rst) any_wake |-> in_ready;
  endproperty
  a_evt_room: assert property (p_evt_room) else $error("wake queue overflow");
endmodule

// >>> common/lmc_cfg.svh
// Purpose: constants for the LIN channel mode control block
// Assumes: 40 MHz system clock
// Notes:   wake filter time in its own unit, its cycle count derived from it; enable and timeout given in cycles
`ifndef LMC_CFG_SVH
`define LMC_CFG_SVH

`define LMC_CLK_MHZ          40
`define LMC_WAKE_FILT_MIN_US 30
`define LMC_WAKE_FILT_MAX_US 150
// filter set between the two limits, 90 us
`define LMC_WAKE_FILT_US     90
`define LMC_WAKE_FILT_CYC    (`LMC_WAKE_FILT_US * `LMC_CLK_MHZ)
`define LMC_TX_EN_CYC        400
`define LMC_DOM_TO_CYC       4000
`define LMC_CNT_W            16
`define LMC_FIFO_DEPTH       4

`endif

// >>> common/lmc_pkg.sv
// Purpose: shared types for the LIN channel mode control block
// Assumes: two channels
// Notes:   mode codes match the channel mode fields
package lmc_pkg;
  typedef enum logic [1:0] {
    LMC_CH_OFF  = 2'b00,
    LMC_CH_WAKE = 2'b01,
    LMC_CH_RXO  = 2'b10,
    LMC_CH_NORM = 2'b11
  } lmc_ch_mode_t;

  typedef enum logic [2:0] {
    LMC_PM_NORMAL  = 3'b000,
    LMC_PM_STOP    = 3'b001,
    LMC_PM_SLEEP   = 3'b010,
    LMC_PM_RESTART = 3'b011,
    LMC_PM_FAILSAF = 3'b100
  } lmc_pwr_mode_t;
endpackage

// >>> logic/lmc_fifo.sv
// Purpose: small valid/ready FIFO for wake event words
// Assumes: single clock, synchronous active-high reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module lmc_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
  assign o_out_valid = (cnt_q != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_q[rd_q];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// >>> verif/lmc_lin_bus_model.sv
// Purpose: far side of two LIN channels, wired bus with pull-up
// Assumes: level 0 is dominant
// Notes:   either party pulling low makes the wire dominant
`timescale 1ns/1ps
module lmc_lin_bus_model (
  // device driver enables
  input  wire logic [1:0] i_oe,
  // far nodes pulling dominant
  input  wire logic [1:0] i_far_dom,
  // resolved wire levels
  output logic      [1:0] o_bus
);
  assign o_bus = ~(i_oe | i_far_dom);
endmodule

// >>> verif/testbench.sv
// Purpose: self-checking bench for the LIN channel mode control block
// Assumes: enable 20 and timeout 50 cycles, wake filter 3600 cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module testbench;
  import lmc_pkg::*;
  // ==========================================
  // signals
  logic       clock = 0, sys_rst = 1, pm_wr = 0, mode_wr = 0, to_dis = 0;
  logic       lss = 0, flash = 0, cs_n = 1, wdog = 0, f_clr = 0, w_clr = 0;
  logic       evt_rdy = 0, uv = 0, rst_req, nrm_req, low_slope, slope_off, wd_set, int_n;
  logic       fault_a, fault_b, evt_valid, seen_rst = 0, seen_wd = 0;
  logic [1:0] mode_a = 0, mode_b = 0, txd = 2'h3, far_dom = 0, rxd, bus, oe, bus_o, wk_stat;
  logic [3:0] evt_data;
  lmc_pwr_mode_t pm = LMC_PM_NORMAL;
  lmc_ch_mode_t  fld_a, fld_b;
  int num_errors = 0, total_checks = 0, cyc = 0;
  // ==========================================
  // design and far side
  lmc_ctrl #(.TX_EN_CYC(20), .DOM_TO_CYC(50)) uut (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_pwr_mode(pm), .i_pwr_mode_wr(pm_wr),
    .o_restart_req(rst_req), .o_normal_req(nrm_req), .i_mode_a_wr_val(mode_a),
    .i_mode_b_wr_val(mode_b), .i_mode_wr(mode_wr), .i_tx_timeout_disable(to_dis),
    .i_low_slope_select(lss), .i_flash_speed_enable(flash), .i_spi_cs_n(cs_n),
    .i_watchdog_on_bus_wake(wdog), .i_fault_clr(f_clr), .i_wake_stat_clr(w_clr),
    .o_channel_a_mode_field(fld_a), .o_channel_b_mode_field(fld_b),
    .o_ch_a_fault_flag(fault_a), .o_ch_b_fault_flag(fault_b),
    .o_wake_source_status(wk_stat), .o_low_slope(low_slope), .o_slope_off(slope_off),
    .o_watchdog_enable_set(wd_set), .o_int_n(int_n), .o_wake_evt_valid(evt_valid),
    .i_wake_evt_ready(evt_rdy), .o_wake_evt_data(evt_data),
    .i_transceiver_supply_uv(uv), .i_lin_transmit_input(txd),
    .o_lin_receive_output(rxd), .i_lin_bus(bus), .o_lin_bus(bus_o), .o_lin_bus_oe(oe));
  lmc_lin_bus_model far_end (.i_oe(oe), .i_far_dom(far_dom), .o_bus(bus));
  // ==========================================
  // clock, pulse catchers, timeout
  initial begin
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    seen_rst <= seen_rst | rst_req;
    seen_wd  <= seen_wd | wd_set;
    cyc      <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ==========================================
  // tasks
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic set_pm(input lmc_pwr_mode_t p);
    pm = p;
    pm_wr = 1;
    step(1);
    pm_wr = 0;
    step(1);
  endtask
  task automatic wr_modes(input logic [1:0] a, input logic [1:0] b);
    mode_a = a;
    mode_b = b;
    mode_wr = 1;
    step(1);
    mode_wr = 0;
    step(1);
  endtask
  task automatic cs_cycle();
    cs_n = 0;
    step(1);
    cs_n = 1;
    step(3);
  endtask
  task automatic bus_wake();
    far_dom = 2'h3;
    step(3700);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================
  // tests
  initial begin
    step(4);
    sys_rst = 0;
    step(1);
    chk(fld_a, 8'h00);
    chk({int_n, rxd, oe}, 8'h1C);
    lss = 1;
    cs_cycle();
    chk(low_slope, 8'h01);
    set_pm(LMC_PM_STOP);
    flash = 1;
    cs_cycle();
    chk(slope_off, 8'h00);
    wr_modes(2'h3, 2'h3);
    chk(fld_a, 8'h00);
    set_pm(LMC_PM_NORMAL);
    cs_cycle();
    chk(slope_off, 8'h01);
    $display("test slope done");
    wr_modes(2'h3, 2'h3);
    txd = 2'h2;
    step(5);
    chk(oe, 8'h00);
    txd = 2'h3;
    step(25);
    txd = 2'h2;
    step(3);
    chk({oe, rxd}, 8'h06);
    chk(bus_o, 8'h00);
    step(60);
    chk({fault_a, oe}, 8'h04);
    txd = 2'h3;
    step(2);
    txd = 2'h2;
    step(2);
    chk(oe, 8'h01);
    txd = 2'h3;
    to_dis = 1;
    step(2);
    txd = 2'h2;
    step(70);
    chk(oe, 8'h01);
    uv = 1;
    step(3);
    chk(oe, 8'h00);
    uv = 0;
    step(3);
    chk(oe, 8'h01);
    txd = 2'h3;
    to_dis = 0;
    $display("test transmit done");
    f_clr = 1;
    step(1);
    f_clr = 0;
    set_pm(LMC_PM_STOP);
    wr_modes(2'h1, 2'h2);
    chk(fld_b, 8'h02);
    wdog = 1;
    bus_wake();
    chk({fault_b, fld_b}, 8'h06);
    far_dom = 0;
    step(4);
    chk({rxd[0], fld_a}, 8'h01);
    chk({int_n, wk_stat}, 8'h01);
    chk({seen_wd, evt_valid, evt_data}, 8'h36);
    evt_rdy = 1;
    step(1);
    evt_rdy = 0;
    set_pm(LMC_PM_STOP);
    chk(rxd[0], 8'h01);
    $display("test stop wake done");
    w_clr = 1;
    step(1);
    w_clr = 0;
    wr_modes(2'h1, 2'h0);
    set_pm(LMC_PM_SLEEP);
    bus_wake();
    far_dom = 0;
    step(4);
    chk({seen_rst, int_n, rxd[0]}, 8'h06);
    chk(wk_stat, 8'h01);
    chk({evt_valid, evt_data}, 8'h14);
    pm = LMC_PM_RESTART;
    step(1);
    chk(nrm_req, 8'h01);
    set_pm(LMC_PM_FAILSAF);
    chk({fld_b, fld_a, rxd}, 8'h17);
    $display("test sleep wake done");
    report_and_stop();
  end
endmodule
